// file: dv/queue_mgr_model.sv
// Queue manager model: holds frames per egress queue, answers grants
`timescale 1ns/1ps
module queue_mgr_model
  import rate_limiter_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Bench control: each pulse adds two frames to the queue
  input wire logic [NUM_Q-1:0] load_in,
  input wire logic [10:0] load_len_in,
  // Limiter side
  input wire logic [NUM_Q-1:0] tx_grant_in,
  output logic [NUM_Q-1:0] tx_req_out,
  output logic [NUM_Q-1:0][10:0] tx_len_out,
  output logic tx_done_out
);
  logic [NUM_Q-1:0][3:0] pend_ff;
  logic [NUM_Q-1:0][10:0] len_ff;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_ff <= '0;
      len_ff <= '0;
      tx_done_out <= 1'b0;
    end else begin
      // Frame finishes one cycle after its grant
      tx_done_out <= |tx_grant_in;
      for (int q = 0; q < NUM_Q; q++) begin
        if (load_in[q]) begin
          pend_ff[q] <= pend_ff[q] + 4'h2;
          len_ff[q] <= load_len_in;
        end else if (tx_grant_in[q]) begin
          pend_ff[q] <= pend_ff[q] - 4'h1;
        end
      end
    end
  end

  // An idle queue shows no stale length: it flips to the inverse
  always_comb begin
    for (int q = 0; q < NUM_Q; q++) begin
      tx_req_out[q] = (pend_ff[q] != 4'h0);
      tx_len_out[q] = tx_req_out[q] ? len_ff[q] : ~len_ff[q];
    end
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the port rate limiter
`timescale 1ns/1ps
module testbench;
  import rate_limiter_pkg::*;
  localparam int TICK = 40;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic rx_valid_in = 1'b0;
  rx_frame_s rx_frame_in = '0;
  logic mem_full_in = 1'b0;
  logic rx_pass_out, rx_drop_out, rx_fc_out;
  logic [NUM_Q-1:0] tx_req_in, tx_grant_out;
  logic [NUM_Q-1:0][10:0] tx_len_in;
  logic tx_done_in;
  logic [NUM_Q-1:0] load = '0;
  logic [NUM_Q-1:0] glog[$];
  int err_total = 0;
  int check_count = 0;
  int np, nd;
  logic [31:0] d;
  logic [1:0] r;

  always #12.5 sys_clk_in = ~sys_clk_in;

  port_rate_limiter #(.TICK_CYCLES(TICK)) dut (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .rx_valid_in(rx_valid_in), .rx_frame_in(rx_frame_in),
    .mem_full_in(mem_full_in), .rx_pass_out(rx_pass_out),
    .rx_drop_out(rx_drop_out), .rx_fc_out(rx_fc_out),
    .tx_req_in(tx_req_in), .tx_len_in(tx_len_in),
    .tx_done_in(tx_done_in), .tx_grant_out(tx_grant_out));

  queue_mgr_model qm (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .load_in(load), .load_len_in(11'h040), .tx_grant_in(tx_grant_out),
    .tx_req_out(tx_req_in), .tx_len_out(tx_len_in),
    .tx_done_out(tx_done_in));

  always @(posedge sys_clk_in) begin
    if (|tx_grant_out) begin
      glog.push_back(tx_grant_out);
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask

  // Kind bits: bcast, mcast, flood
  function automatic rx_frame_s mk(input logic [10:0] len,
                                   input logic [2:0] k);
    rx_frame_s f;
    f = '0;
    f.len = len;
    {f.bcast, f.mcast, f.flood} = k;
    return f;
  endfunction

  // Whether a frame kind falls under a count select value
  function automatic bit counted(input int sel, input int kind);
    return (kind == 0) ? (sel <= 1) : (kind == 1) ? (sel <= 2) : 1'b1;
  endfunction

  task automatic send(input rx_frame_s f, output logic [1:0] res);
    @(posedge sys_clk_in);
    rx_valid_in <= 1'b1;
    rx_frame_in <= f;
    @(posedge sys_clk_in);
    rx_valid_in <= 1'b0;
    #1 res = {rx_pass_out, rx_drop_out};
  endtask

  // Six back-to-back frames on a bucket refilled by a fresh tick
  task automatic burst(input logic [10:0] len, input logic [2:0] k);
    logic [1:0] res;
    np = 0;
    nd = 0;
    repeat (TICK + 5) @(posedge sys_clk_in);
    repeat (6) begin
      send(mk(len, k), res);
      np += res[1];
      nd += res[0];
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_total++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h7639));
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    wr(OFF_ING, 32'h1);
    wr(OFF_EGR, 32'h5);
    @(posedge sys_clk_in);
    load <= 4'h1;
    @(posedge sys_clk_in);
    load <= 4'h0;
    send(mk(11'h040, 3'h0), r);
    chk("empty bucket", 2'b01, r);
    rd(OFF_CTRL, d);
    chk("ctrl reset", 32'(CTRL_RST), d);
    rd(OFF_PCPMAP, d);
    chk("pcp map reset", 32'(PCPMAP_RST), d);
    rd(OFF_RATIO + 8'h0C, d);
    chk("top ratio reset", 32'h8, d);
    rd(8'h70, d);
    chk("unmapped", 32'h0, d);
    rd(OFF_CTRL + 8'h01, d);
    chk("misaligned", 32'h0, d);
    chk("grant before refill", 32'h0, 32'(glog.size()));
    repeat (200) @(posedge sys_clk_in);
    chk("egress after refill", 32'h2, 32'(glog.size()));
    rd(OFF_STATUS, d);
    chk("drop count", 32'h1, {16'h0, d[15:0]});
    burst(11'h040, 3'h0);
    chk("over limit", 32'h1, 32'(np >= 1 && nd >= 1));
    wr(OFF_RLCTRL, 32'h1 << RL_FC);
    burst(11'h040, 3'h0);
    chk("fc passes", 32'h6, 32'(np));
    chk("fc raised", 32'h1, 32'(rx_fc_out));
    for (int s = 0; s < 4; s++) begin
      wr(OFF_RLCTRL, 32'(s) << RL_SEL);
      for (int k = 0; k < 3; k++) begin
        burst(11'h040, 3'h1 << k);
        chk("count select", 32'(counted(s, k)), 32'(nd > 0));
      end
    end
    chk("fc released", 32'h0, 32'(rx_fc_out));
    wr(OFF_ING, 32'h32);
    wr(OFF_CTRL, 32'(SPD_10));
    // Broadcast frames, so the last count select still polices them
    burst(11'h5DC, 3'h4);
    chk("10M unlimited", 32'h0, 32'(nd));
    wr(OFF_CTRL, 32'h1);
    burst(11'h5DC, 3'h4);
    chk("100M limited", 32'h1, 32'(nd > 0));
    wr(OFF_ING, 32'h0);
    mem_full_in <= 1'b1;
    send(mk(11'h040, 3'h0), r);
    chk("memory full", 2'b01, r);
    mem_full_in <= 1'b0;
    repeat (20) begin
      rx_frame_s f;
      f = rx_frame_s'({$urandom, $urandom});
      f.len = 11'(64 + $urandom_range(0, 1454));
      send(f, r);
      chk("line rate", 2'b10, r);
    end
    // Queue-based mode set first, as software must do
    wr(OFF_CTRL, 32'h1 | (32'h1 << CTRL_QEN) |
       (32'(QM_4Q) << CTRL_QM));
    for (int q = 0; q < NUM_Q; q++) begin
      wr(OFF_EGR + 8'(4 * q), 32'h0);
    end
    @(posedge sys_clk_in);
    load <= 4'hF;
    @(posedge sys_clk_in);
    load <= 4'h0;
    repeat (600) @(posedge sys_clk_in);
    chk("grant total", 32'hA, 32'(glog.size()));
    for (int i = 0; i < 8 && 2 + i < glog.size(); i++) begin
      chk("grant order", 32'(4'h8 >> (i / 2)), 32'(glog[2 + i]));
    end
    // Top queue at 1 Mbps leaves queue 0 one eighth: a frame per 4 ticks
    wr(OFF_EGR + 8'h0C, 32'h1);
    @(posedge sys_clk_in);
    load <= 4'h1;
    @(posedge sys_clk_in);
    load <= 4'h0;
    repeat (80) @(posedge sys_clk_in);
    chk("ratio first", 32'hB, 32'(glog.size()));
    repeat (200) @(posedge sys_clk_in);
    chk("ratio second", 32'hC, 32'(glog.size()));
    // One fine-step credit pays for one frame; the rest of the burst drops
    wr(OFF_PRIO, 32'h3 << PRIO_PORT);
    wr(OFF_ING + 8'h0C, 32'h65);
    burst(11'h040, 3'h4);
    chk("port priority", 32'h5, 32'(nd));
    wr(OFF_PRIO, 32'h2 << PRIO_PORT);
    wr(OFF_ING + 8'h08, 32'h65);
    wr(OFF_CTRL, 32'h1 | (32'h1 << CTRL_PKT) | (32'h1 << CTRL_QEN) |
       (32'(QM_4Q) << CTRL_QM));
    burst(11'h040, 3'h4);
    chk("packet rate", 32'h5, 32'(nd));
    wrap_up();
  end
endmodule

// file: hdl/port_rate_limiter.sv
// Per-port ingress policer and egress shaper for one switch port
`timescale 1ns/1ps
module port_rate_limiter
  import rate_limiter_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Ingress frames from the port MAC
  input wire logic rx_valid_in,
  input wire rx_frame_s rx_frame_in,
  input wire logic mem_full_in,
  output logic rx_pass_out,
  output logic rx_drop_out,
  output logic rx_fc_out,
  // Egress queues of the queue manager
  input wire logic [NUM_Q-1:0] tx_req_in,
  input wire logic [NUM_Q-1:0][10:0] tx_len_in,
  input wire logic tx_done_in,
  output logic [NUM_Q-1:0] tx_grant_out
);

  localparam int NB = 3 * NUM_Q;
  localparam int EG = NUM_Q;
  localparam int BD = 2 * NUM_Q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [4:0] rlctrl_ff;
  logic [6:0] prio_ff;
  logic [6:0] ing_code_ff [NUM_Q];
  logic [6:0] egr_code_ff [NUM_Q];
  logic [3:0] ratio_ff [NUM_Q];
  logic [15:0] pcpmap_ff;
  logic [127:0] dscpmap_ff;
  logic [15:0] drop_cnt_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic aligned;
  logic [1:0] ridx;
  logic [1:0] spd;
  logic pkt_mode;
  logic q_en;
  logic [1:0] qmode;
  logic fc_en;
  logic [NB-1:0] ok;

  assign aligned = (reg_addr_in[1:0] == 2'h0);
  assign ridx = reg_addr_in[3:2];
  assign spd = ctrl_ff[CTRL_SPD +: 2];
  assign pkt_mode = ctrl_ff[CTRL_PKT];
  assign q_en = ctrl_ff[CTRL_QEN];
  assign qmode = ctrl_ff[CTRL_QM +: 2];
  assign fc_en = rlctrl_ff[RL_FC];

  // Receive and transmit codes live in separate banks
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_ff <= CTRL_RST;
      rlctrl_ff <= 5'h00;
      prio_ff <= 7'h00;
      pcpmap_ff <= PCPMAP_RST;
      dscpmap_ff <= DSCPMAP_RST;
      for (int q = 0; q < NUM_Q; q++) begin
        ing_code_ff[q] <= 7'h00;
        egr_code_ff[q] <= 7'h00;
        ratio_ff[q] <= RATIO_RST[4*q +: 4];
      end
    end else if (reg_wr_in && aligned) begin
      if (reg_addr_in == OFF_CTRL) ctrl_ff <= reg_wdata_in[7:0];
      if (reg_addr_in == OFF_RLCTRL) rlctrl_ff <= reg_wdata_in[4:0];
      if (reg_addr_in == OFF_PRIO) prio_ff <= reg_wdata_in[6:0];
      if (reg_addr_in == OFF_PCPMAP) pcpmap_ff <= reg_wdata_in[15:0];
      if ((reg_addr_in & BANK_MASK) == OFF_DSCPMAP) begin
        dscpmap_ff[32*ridx +: 32] <= reg_wdata_in;
      end
      if ((reg_addr_in & BANK_MASK) == OFF_ING) begin
        ing_code_ff[ridx] <= reg_wdata_in[6:0];
      end
      if ((reg_addr_in & BANK_MASK) == OFF_EGR) begin
        egr_code_ff[ridx] <= reg_wdata_in[6:0];
      end
      if ((reg_addr_in & BANK_MASK) == OFF_RATIO) begin
        ratio_ff[ridx] <= reg_wdata_in[3:0];
      end
    end
  end

  // Unmapped or misaligned reads return zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (reg_rd_in && aligned) begin
      case (reg_addr_in & BANK_MASK)
        OFF_CTRL: begin
          if (reg_addr_in == OFF_CTRL) nxt_rdata = {24'h0, ctrl_ff};
          if (reg_addr_in == OFF_RLCTRL) nxt_rdata = {27'h0, rlctrl_ff};
          if (reg_addr_in == OFF_PRIO) nxt_rdata = {25'h0, prio_ff};
        end
        OFF_ING: nxt_rdata = {25'h0, ing_code_ff[ridx]};
        OFF_EGR: nxt_rdata = {25'h0, egr_code_ff[ridx]};
        OFF_RATIO: nxt_rdata = {28'h0, ratio_ff[ridx]};
        OFF_DSCPMAP: nxt_rdata = dscpmap_ff[32*ridx +: 32];
        default: begin
          if (reg_addr_in == OFF_PCPMAP) nxt_rdata = {16'h0, pcpmap_ff};
          if (reg_addr_in == OFF_STATUS) begin
            nxt_rdata = {ok, 3'h0, rx_fc_out, drop_cnt_ff};
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rdata_ff <= 32'h00000000;
    else rdata_ff <= nxt_rdata;
  end
  assign reg_rdata_out = rdata_ff;

  // ----------------------------------------------------------------
  // Refill tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_ff;
  logic tick_ff;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 32'h00000000;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
      tick_ff <= 1'b0;
    end
  end

  tick_gap_a: assert property (tick_ff |=> !tick_ff [*8])
    else $error("refill tick repeated too soon");

  // ----------------------------------------------------------------
  // Bucket rates: 0..3 ingress, 4..7 egress, 8..11 egress bound
  // ----------------------------------------------------------------
  rate_s rate [NB];
  rate_s own;
  rate_s hi;
  logic [1:0] hq;
  logic multi;
  logic [24:0] rw;

  assign multi = q_en && (qmode == QM_2Q || qmode == QM_4Q);
  assign hq = !multi ? 2'h0 : (qmode == QM_4Q) ? 2'h3 : 2'h1;

  always_comb begin
    rw = 25'h0000000;
    own = '0;
    hi = rate_decode(egr_code_ff[hq], spd, pkt_mode);
    for (int q = 0; q < NUM_Q; q++) begin
      rate[q] = rate_decode(ing_code_ff[q], spd, pkt_mode);
      own = rate_decode(egr_code_ff[q], spd, pkt_mode);
      rate[EG+q] = own;
      // Lower queues trail the top queue; the top keeps its exact rate
      if (multi && 2'(q) < hq && !hi.unl) begin
        rw = 25'(hi.amt) * 25'(ratio_ff[q]);
        rw = rw >> RATIO_SHIFT;
        if (own.unl || rw < 25'(own.amt)) begin
          rate[EG+q].unl = 1'b0;
          rate[EG+q].amt = (rw > 25'h01FFFFF) ? 21'h1FFFFF : rw[20:0];
        end
      end
      rate[BD+q] = '0;
      rate[BD+q].unl = 1'b1;
      if (pkt_mode) begin
        rate[BD+q] = rate_decode(bound_code(egr_code_ff[q]), spd, 1'b0);
      end
    end
  end

  hi_exact_a: assert property (
    multi |-> rate[EG+hq] == rate_decode(egr_code_ff[hq], spd, pkt_mode))
    else $error("top egress queue rate altered by ratio");

  ten_unlimited_a: assert property (
    spd == SPD_10 && ing_code_ff[0] == 7'h32 |-> rate[0].unl)
    else $error("10 Mbps port limited above line rate");

  // ----------------------------------------------------------------
  // Credit counters
  // ----------------------------------------------------------------
  logic signed [23:0] credit_ff [NB];
  logic signed [23:0] nxt_credit [NB];
  logic [NB-1:0] chg;
  logic [15:0] cost [NB];

  // Charge and refill in the same cycle both apply, so no frame is missed
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      nxt_credit[b] = credit_ff[b];
      if (rate[b].unl) begin
        nxt_credit[b] = 24'sh000000;
      end else begin
        if (tick_ff) begin
          nxt_credit[b] = credit_ff[b] + $signed({3'h0, rate[b].amt});
          // Depth of one tick keeps bursts short
          if (nxt_credit[b] > $signed({3'h0, rate[b].amt})) begin
            nxt_credit[b] = $signed({3'h0, rate[b].amt});
          end
        end
        if (chg[b]) begin
          nxt_credit[b] = nxt_credit[b] - $signed({8'h00, cost[b]});
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int b = 0; b < NB; b++) credit_ff[b] <= 24'sh000000;
    end else begin
      for (int b = 0; b < NB; b++) credit_ff[b] <= nxt_credit[b];
    end
  end

  always_comb begin
    for (int b = 0; b < NB; b++) begin
      ok[b] = rate[b].unl || (credit_ff[b] > 24'sh000000);
    end
  end

  code_zero_a: assert property (ing_code_ff[0] == 7'h00 |-> ok[0])
    else $error("code zero still limited");

  // Frame cost in bits, DA through FCS plus optional overhead
  function automatic logic [15:0] bit_cost(input logic [10:0] len);
    logic [15:0] by;
    by = {5'h00, len};
    if (ctrl_ff[CTRL_IFG]) by = by + IFG_BYTES;
    if (ctrl_ff[CTRL_PRE]) by = by + PRE_BYTES;
    return by << 3;
  endfunction

  // ----------------------------------------------------------------
  // Ingress policing
  // ----------------------------------------------------------------
  logic counted;
  logic [1:0] prio;
  logic [1:0] ibkt;
  logic blk;
  logic rx_pass_ff;
  logic rx_drop_ff;
  logic rx_fc_ff;

  always_comb begin
    case (rlctrl_ff[RL_SEL +: 2])
      2'h0: counted = 1'b1;
      2'h1: counted = rx_frame_in.bcast || rx_frame_in.mcast ||
                      rx_frame_in.flood;
      2'h2: counted = rx_frame_in.bcast || rx_frame_in.mcast;
      default: counted = rx_frame_in.bcast;
    endcase
    case (prio_ff[PRIO_SRC +: 2])
      SRC_PORT: prio = prio_ff[PRIO_PORT +: 2];
      SRC_DSCP: prio = dscpmap_ff[{rx_frame_in.dscp, 1'b0} +: 2];
      default: prio = pcpmap_ff[{rx_frame_in.pcp, 1'b0} +: 2];
    endcase
    ibkt = 2'h0;
    if (multi) ibkt = (prio > hq) ? hq : prio;
    // Full queue memory also pushes back on ingress
    blk = mem_full_in || (counted && !ok[ibkt]);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_pass_ff <= 1'b0;
      rx_drop_ff <= 1'b0;
    end else begin
      rx_pass_ff <= rx_valid_in && (!blk || fc_en);
      rx_drop_ff <= rx_valid_in && blk && !fc_en;
    end
  end

  // Pause holds until the next refill tick, unless an overrun lands in that same cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rx_fc_ff <= 1'b0;
    else if (rx_valid_in && blk && fc_en) rx_fc_ff <= 1'b1;
    else if (tick_ff) rx_fc_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) drop_cnt_ff <= 16'h0000;
    else if (rx_drop_ff && drop_cnt_ff != 16'hFFFF) begin
      drop_cnt_ff <= drop_cnt_ff + 16'h0001;
    end
  end

  assign rx_pass_out = rx_pass_ff;
  assign rx_drop_out = rx_drop_ff;
  assign rx_fc_out = rx_fc_ff;

  fc_no_drop_a: assert property (
    rx_valid_in && blk && fc_en |=> rx_pass_out && !rx_drop_out && rx_fc_out)
    else $error("frame dropped while flow control enabled");

  drop_no_fc_a: assert property (
    rx_valid_in && blk && !fc_en |=> rx_drop_out && !rx_pass_out)
    else $error("over-limit frame not dropped");

  uncounted_pass_a: assert property (
    rx_valid_in && !counted && !mem_full_in |=> rx_pass_out)
    else $error("uncounted frame was policed");

  // ----------------------------------------------------------------
  // Egress shaping
  // ----------------------------------------------------------------
  eg_state_e eg_state_ff;
  logic [NUM_Q-1:0] grant_ff;
  logic [NUM_Q-1:0] elig;
  logic [1:0] eq;
  logic [1:0] ebkt;
  logic pick;

  // Strict priority among queues whose buckets hold credit
  always_comb begin
    pick = 1'b0;
    eq = 2'h0;
    for (int q = 0; q < NUM_Q; q++) begin
      ebkt = multi ? 2'(q) : 2'h0;
      elig[q] = tx_req_in[q] && ok[EG+ebkt] && ok[BD+ebkt];
      if (elig[q]) begin
        pick = 1'b1;
        eq = 2'(q);
      end
    end
    ebkt = multi ? eq : 2'h0;
    chg = '0;
    for (int b = 0; b < NB; b++) cost[b] = 16'h0000;
    if (rx_valid_in && counted && !blk) begin
      chg[ibkt] = 1'b1;
      cost[ibkt] = pkt_mode ? PKT_COST : bit_cost(rx_frame_in.len);
    end
    // Waiting for credit stretches the gap before the next frame
    if (eg_state_ff == EG_IDLE && pick) begin
      chg[EG+ebkt] = 1'b1;
      chg[BD+ebkt] = 1'b1;
      cost[EG+ebkt] = pkt_mode ? PKT_COST : bit_cost(tx_len_in[eq]);
      cost[BD+ebkt] = bit_cost(tx_len_in[eq]);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eg_state_ff <= EG_IDLE;
      grant_ff <= '0;
    end else begin
      grant_ff <= '0;
      unique case (eg_state_ff)
        EG_IDLE: begin
          if (pick) begin
            grant_ff[eq] <= 1'b1;
            eg_state_ff <= EG_GRANT;
          end
        end
        EG_GRANT: begin
          eg_state_ff <= tx_done_in ? EG_IDLE : EG_BUSY;
        end
        EG_BUSY: begin
          if (tx_done_in) eg_state_ff <= EG_IDLE;
        end
        default: eg_state_ff <= EG_IDLE;
      endcase
    end
  end

  assign tx_grant_out = grant_ff;

  sequence eg_pick_s;
    eg_state_ff == EG_IDLE && pick;
  endsequence

  sequence eg_pulse_s;
    (tx_grant_out != '0) ##1 (tx_grant_out == '0);
  endsequence

  grant_pulse_a: assert property (eg_pick_s |=> eg_pulse_s)
    else $error("eligible queue not granted for one cycle");

  grant_elig_a: assert property (
    tx_grant_out != '0 |-> (tx_grant_out & ~$past(elig)) == '0)
    else $error("grant issued without credit");

  grant_onehot_a: assert property ($onehot0(tx_grant_out))
    else $error("more than one queue granted");

  busy_hold_a: assert property (
    eg_state_ff == EG_BUSY && !tx_done_in |=> tx_grant_out == '0)
    else $error("grant during frame in flight");

endmodule

// file: hdl/rate_limiter_pkg.sv
// Constants, types and rate decoding shared by the port rate limiter
//
// Overview of operation
// - Bit-rate limits under 1 Mbps step by 64 Kbps, or 640 Kbps at gigabit
// - Bit-rate limits over 1 Mbps step by 1 Mbps, or 10 Mbps at gigabit
// - Packet-rate fine steps are 128 pps after a 64 pps first step; x10 gigabit
// - Code 0 is line rate, 1-100 coarse multiples, 101 up fine steps
// - Egress packet-rate limits are also capped by a bound bit-rate code
// - On 10 Mbps ports a setting above 10 Mbps is unlimited
// - Receive and transmit limits are set and applied independently
// - Receive limits per priority, transmit limits per queue
// - Bit-rate frame size is DA to FCS plus optional gap and preamble
// - A 2-bit selector picks which ingress frame types are counted
// - Over-limit ingress frames drop, or raise flow control when enabled
// - Priority comes from port, 802.1p or DiffServ; port value is 2 bits
// - 802.1p and DiffServ values remap to priorities 0-3 via tables
// - Ingress priorities 0-3 each have a code; 2-queue uses 0 and 1
// - Egress queues 0-3 each have a code; 2-queue uses 0 and 1
// - Egress uses a leaky bucket per queue, stretching the gap per frame
// - Excess egress waits in queue memory; full memory drops or pauses
// - Top queue gets the table rate, lower ones follow ratio 8:4:2:1
// - Ratios are programmable per queue and never throttle the top queue
package rate_limiter_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RLCTRL = 8'h04;
  localparam logic [7:0] OFF_PRIO = 8'h08;
  localparam logic [7:0] OFF_ING = 8'h10;
  localparam logic [7:0] OFF_EGR = 8'h20;
  localparam logic [7:0] OFF_RATIO = 8'h30;
  localparam logic [7:0] OFF_PCPMAP = 8'h40;
  localparam logic [7:0] OFF_DSCPMAP = 8'h50;
  localparam logic [7:0] OFF_STATUS = 8'h60;
  localparam logic [7:0] BANK_MASK = 8'hF0;
  localparam int CTRL_SPD = 0;
  localparam int CTRL_PKT = 2;
  localparam int CTRL_IFG = 3;
  localparam int CTRL_PRE = 4;
  localparam int CTRL_QEN = 5;
  localparam int CTRL_QM = 6;
  localparam int RL_SEL = 2;
  localparam int RL_FC = 4;
  localparam int PRIO_PORT = 3;
  localparam int PRIO_SRC = 5;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [15:0] PCPMAP_RST = 16'hFA50;
  localparam logic [127:0] DSCPMAP_RST =
    128'hFFFFFFFF_AAAAAAAA_55555555_00000000;
  localparam logic [15:0] RATIO_RST = 16'h8421;
  localparam int RATIO_SHIFT = 3;

  // ----------------------------------------------------------------
  // Encodings and rate units (bits or milli-packets per tick)
  // ----------------------------------------------------------------
  localparam int NUM_Q = 4;
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] QM_2Q = 2'h1;
  localparam logic [1:0] QM_4Q = 2'h2;
  localparam logic [1:0] SRC_PORT = 2'h0;
  localparam logic [1:0] SRC_DSCP = 2'h2;
  localparam logic [6:0] CODE_TEN_MAX = 7'h0A;
  localparam logic [6:0] CODE_COARSE_MAX = 7'h64;
  localparam logic [6:0] CODE_FINE_1ST = 7'h65;
  localparam logic [20:0] BPS_COARSE = 21'h0003E8;
  localparam logic [20:0] PPS_COARSE = 21'h000780;
  localparam logic [20:0] BPS_FINE = 21'h000040;
  localparam logic [20:0] PPS_FINE = 21'h000080;
  localparam logic [20:0] PPS_FIRST = 21'h000040;
  localparam logic [20:0] GIG_MULT = 21'h00000A;
  localparam logic [15:0] PKT_COST = 16'h03E8;
  localparam logic [15:0] IFG_BYTES = 16'h000C;
  localparam logic [15:0] PRE_BYTES = 16'h0008;

  typedef struct packed {
    logic unl;
    logic [20:0] amt;
  } rate_s;

  typedef struct packed {
    logic [10:0] len;
    logic bcast;
    logic mcast;
    logic flood;
    logic [2:0] pcp;
    logic [5:0] dscp;
  } rx_frame_s;

  typedef enum logic [1:0] {
    EG_IDLE = 2'b00,
    EG_GRANT = 2'b01,
    EG_BUSY = 2'b11
  } eg_state_e;

  function automatic rate_s rate_decode(input logic [6:0] code,
                                        input logic [1:0] spd,
                                        input logic pkt);
    rate_s r;
    logic [20:0] a;
    r.unl = 1'b0;
    a = 21'h000000;
    if (code == 7'h00 || (spd == SPD_10 && code > CODE_TEN_MAX &&
        code <= CODE_COARSE_MAX)) begin
      r.unl = 1'b1;
    end else if (code <= CODE_COARSE_MAX) begin
      a = 21'(code) * (pkt ? PPS_COARSE : BPS_COARSE);
    end else if (pkt) begin
      a = (code == CODE_FINE_1ST) ? PPS_FIRST :
          21'(code - CODE_FINE_1ST) * PPS_FINE;
    end else begin
      a = 21'(code - CODE_COARSE_MAX) * BPS_FINE;
    end
    r.amt = (spd == SPD_1000) ? 21'(a * GIG_MULT) : a;
    return r;
  endfunction

  function automatic logic [6:0] bound_code(input logic [6:0] c);
    logic [6:0] b;
    case (c)
      7'h00: b = 7'h00;
      7'h01: b = 7'h03;
      7'h02: b = 7'h06;
      7'h65: b = 7'h66;
      7'h66: b = 7'h68;
      7'h67: b = 7'h6C;
      7'h68: b = 7'h70;
      default: begin
        if (c <= CODE_TEN_MAX) b = 7'h0A;
        else if (c <= CODE_COARSE_MAX) b = c;
        else if (c < 7'h6C) b = 7'h01;
        else if (c < 7'h71) b = 7'h02;
        else b = 7'h03;
      end
    endcase
    return b;
  endfunction

endpackage
